// file: core/xe_alu.sv
// Combinational result, flag and skip logic of the execute subset.
// Assumes operands held stable by the sequencer for one cycle.
`timescale 1ns/100ps
module xe_alu (
   xe_alu_if.alu a_if
);
   logic [7:0] sub;
   logic borrow;
   logic [8:0] diff;
   logic [4:0] ndiff;

   always_comb begin
      if (a_if.op == xe_pkg::OP_SUB_IMM ||
          a_if.op == xe_pkg::OP_EXOR_IMM) begin
         sub = a_if.imm;
      end else begin
         sub = a_if.mem;
      end
      borrow = (a_if.op == xe_pkg::OP_SUB_BORROW_ACC ||
                a_if.op == xe_pkg::OP_SUB_BORROW_MEM) ? ~a_if.cin : 1'b0;
      diff = {1'b0, a_if.acc} - {1'b0, sub} - {8'h00, borrow};
      ndiff = {1'b0, a_if.acc[3:0]} - {1'b0, sub[3:0]} -
              {4'h0, borrow};
   end

   always_comb begin
      a_if.result = a_if.mem;
      a_if.wr_acc = 1'b0;
      a_if.wr_mem = 1'b0;
      a_if.upd_arith = 1'b0;
      a_if.upd_z = 1'b0;
      a_if.upd_c = 1'b0;
      a_if.c_out = a_if.cin;
      a_if.skip = 1'b0;
      case (a_if.op)
         xe_pkg::OP_ROT_RIGHT_FLAG_ACC: begin
            a_if.result = {a_if.cin, a_if.mem[xe_pkg::MSB:1]};
            a_if.c_out = a_if.mem[0];
            a_if.upd_c = 1'b1;
            a_if.wr_acc = 1'b1;
         end
         xe_pkg::OP_SUB_BORROW_ACC, xe_pkg::OP_SUB_ACC,
         xe_pkg::OP_SUB_IMM: begin
            a_if.result = diff[7:0];
            a_if.c_out = ~diff[8];
            a_if.upd_arith = 1'b1;
            a_if.wr_acc = 1'b1;
         end
         xe_pkg::OP_SUB_BORROW_MEM, xe_pkg::OP_SUB_MEM: begin
            a_if.result = diff[7:0];
            a_if.c_out = ~diff[8];
            a_if.upd_arith = 1'b1;
            a_if.wr_mem = 1'b1;
         end
         xe_pkg::OP_DEC_SKIP, xe_pkg::OP_DEC_SKIP_ACC: begin
            a_if.result = a_if.mem - xe_pkg::ONE;
            a_if.skip = (a_if.result == xe_pkg::NIL);
            a_if.wr_mem = (a_if.op == xe_pkg::OP_DEC_SKIP);
            a_if.wr_acc = (a_if.op == xe_pkg::OP_DEC_SKIP_ACC);
         end
         xe_pkg::OP_INC_SKIP, xe_pkg::OP_INC_SKIP_ACC: begin // see RULE13
            a_if.result = a_if.mem + xe_pkg::ONE;
            a_if.skip = (a_if.result == xe_pkg::NIL);
            a_if.wr_mem = (a_if.op == xe_pkg::OP_INC_SKIP);
            a_if.wr_acc = (a_if.op == xe_pkg::OP_INC_SKIP_ACC);
         end
         xe_pkg::OP_SET_BYTE: begin // see RULE10
            a_if.result = xe_pkg::ALL_ONES;
            a_if.wr_mem = 1'b1;
         end
         xe_pkg::OP_SET_BIT: begin // see RULE11
            a_if.result = a_if.mem | (xe_pkg::ONE << a_if.bit_sel);
            a_if.wr_mem = 1'b1;
         end
         xe_pkg::OP_SKIP_BIT_SET: begin // see RULE14
            a_if.skip = a_if.mem[a_if.bit_sel];
         end
         xe_pkg::OP_SKIP_BIT_CLEAR: begin // see RULE18
            a_if.skip = ~a_if.mem[a_if.bit_sel];
         end
         xe_pkg::OP_NIBBLE_MEM, xe_pkg::OP_NIBBLE_ACC: begin // see RULE15
            a_if.result = {a_if.mem[xe_pkg::NIB-1:0],
                           a_if.mem[xe_pkg::MSB:xe_pkg::NIB]};
            a_if.wr_mem = (a_if.op == xe_pkg::OP_NIBBLE_MEM);
            a_if.wr_acc = (a_if.op == xe_pkg::OP_NIBBLE_ACC);
         end
         xe_pkg::OP_SKIP_NIL: begin // see RULE16
            a_if.skip = (a_if.mem == xe_pkg::NIL);
         end
         xe_pkg::OP_COPY_SKIP_NIL: begin // see RULE17
            a_if.skip = (a_if.mem == xe_pkg::NIL);
            a_if.wr_acc = 1'b1;
         end
         xe_pkg::OP_EXOR_ACC, xe_pkg::OP_EXOR_IMM: begin
            a_if.result = a_if.acc ^ sub;
            a_if.upd_z = 1'b1;
            a_if.wr_acc = 1'b1;
         end
         xe_pkg::OP_EXOR_MEM: begin
            a_if.result = a_if.acc ^ sub;
            a_if.upd_z = 1'b1;
            a_if.wr_mem = 1'b1;
         end
         default: begin
            a_if.result = a_if.mem;
         end
      endcase
   end

   // Half carry is the inverted nibble borrow, as carry is for the byte
   assign a_if.ac_out = ~ndiff[4];
   assign a_if.ov_out = (a_if.acc[xe_pkg::MSB] ^ sub[xe_pkg::MSB]) &
                        (a_if.acc[xe_pkg::MSB] ^ diff[xe_pkg::MSB]);
   assign a_if.z_out = (a_if.result == xe_pkg::NIL);
endmodule

// file: core/xe_alu_if.sv
// Operands and results between the execute sequencer and its ALU.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface xe_alu_if;
   xe_pkg::xe_op_e op;
   logic [7:0] acc;
   logic [7:0] mem;
   logic [7:0] imm;
   logic [2:0] bit_sel;
   logic cin;
   logic [7:0] result;
   logic wr_acc;
   logic wr_mem;
   logic upd_arith;
   logic upd_z;
   logic upd_c;
   logic c_out;
   logic ac_out;
   logic ov_out;
   logic z_out;
   logic skip;
   modport core (output op, acc, mem, imm, bit_sel, cin,
      input result, wr_acc, wr_mem, upd_arith, upd_z, upd_c,
      c_out, ac_out, ov_out, z_out, skip);
   modport alu (input op, acc, mem, imm, bit_sel, cin,
      output result, wr_acc, wr_mem, upd_arith, upd_z, upd_c,
      c_out, ac_out, ov_out, z_out, skip);
endinterface

// file: core/xe_dmem.sv
// Data memory with one write port and a registered read port.
// Assumes read and write on the same clock; a read that meets a
// write to the same word returns the old contents.
`timescale 1ns/100ps
module xe_dmem #(
   parameter int DEPTH = xe_pkg::DM_DEPTH,
   parameter int AW = xe_pkg::DM_AW,
   parameter int DW = xe_pkg::DATA_W
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [DEPTH];

   // Writes past the top of the array are dropped
   always_ff @(posedge mclk_i) begin
      if (we_i && (int'(waddr_i) < DEPTH)) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Unmapped addresses read as zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rdata_o <= '0;
      end else if (int'(raddr_i) < DEPTH) begin
         rdata_o <= mem[raddr_i];
      end else begin
         rdata_o <= '0;
      end
   end
endmodule

// file: core/xe_exec.sv
// Execute sequencer: accumulator, flags, data memory, table latch.
// Assumes requests, table pointers and program data come from logic on
// mclk_i; program memory answers one cycle after prog_rd_o.
//
// Operation
// RULE1: Rotate right through carry into accumulator; memory untouched
// RULE2: Accumulator minus operand minus inverted carry into accumulator
// RULE3: Same borrow difference written back to memory, flags updated
// RULE4: Subtract carry is clear when negative, set when zero or positive
// RULE5: Plain subtract of memory or immediate into accumulator
// RULE6: Accumulator minus memory written back to memory
// RULE7: A taken skip adds one dummy cycle, two cycles in all
// RULE8: Decrement memory, write back, skip on zero, flags kept
// RULE9: Memory minus one into accumulator, skip on zero, flags kept
// RULE10: Set byte writes all ones to memory, flags kept
// RULE11: Set bit forces one selected bit, others and flags kept
// RULE12: Increment memory, write back, skip on zero, flags kept
// RULE13: Memory plus one into accumulator, skip on zero, flags kept
// RULE14: Skip when selected bit is one; nothing else changes
// RULE15: Nibble exchange to memory or to accumulator, flags kept
// RULE16: Skip when whole byte is zero; nothing else changes
// RULE17: Copy memory to accumulator and skip when zero, flags kept
// RULE18: Skip when selected bit is zero; nothing else changes
// RULE19: Table fetch via both pointers; low byte to memory, high latched
// RULE20: Last page table fetch uses low pointer only
// RULE21: Exclusive or into accumulator or memory, zero flag only
// RULE22: Zero flag tracks all-zero result; plain forms take one cycle
`timescale 1ns/100ps
module xe_exec #(
   parameter int DEPTH = xe_pkg::DM_DEPTH
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic op_valid_i,
   input wire xe_pkg::xe_op_e op_i,
   input wire logic [7:0] op_addr_i,
   input wire logic [2:0] op_bit_i,
   input wire logic [7:0] op_imm_i,
   input wire logic [3:0] table_pointer_high_i,
   input wire logic [7:0] table_pointer_low_i,
   input wire logic [15:0] prog_data_i,
   input wire logic load_we_i,
   input wire logic [7:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   output logic op_ready_o,
   output logic done_o,
   output logic skip_o,
   output logic prog_rd_o,
   output logic [11:0] prog_addr_o,
   output logic [7:0] mem_data_o,
   output logic [7:0] accum_o,
   output logic carry_o,
   output logic zero_o,
   output logic half_carry_flag_o,
   output logic signed_range_flag_o,
   output logic [7:0] table_high_latch_o
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_DUMMY
   } xe_state_e;

   xe_state_e state;
   xe_state_e next_state;
   xe_pkg::xe_op_e cur_op;
   logic [7:0] cur_addr;
   logic [2:0] cur_bit;
   logic [7:0] cur_imm;
   logic [7:0] accum;
   logic carry;
   logic zero;
   logic half_carry_flag;
   logic signed_range_flag;
   logic [7:0] table_high_latch;
   logic [7:0] rdata;
   logic [7:0] raddr;
   logic mem_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic accept;
   logic exec;
   logic is_table;
   logic [11:0] next_prog_addr;
   logic [11:0] prog_addr;

   xe_alu_if a_if ();

   function automatic logic table_op(input xe_pkg::xe_op_e op);
      return (op == xe_pkg::OP_TABLE_FETCH ||
              op == xe_pkg::OP_TABLE_FETCH_LAST);
   endfunction

   assign op_ready_o = (state == ST_IDLE);
   assign accept = op_ready_o && op_valid_i;
   assign exec = (state == ST_EXEC);
   assign is_table = table_op(cur_op);

   // Operand read starts at acceptance so execution needs one more cycle
   assign raddr = op_ready_o ? op_addr_i : cur_addr;

   always_comb begin
      mem_we = 1'b0;
      mem_waddr = cur_addr;
      mem_wdata = a_if.result;
      if (exec && is_table) begin
         mem_we = 1'b1; // see RULE19
         mem_wdata = prog_data_i[xe_pkg::TBL_HI_BYTE-1:xe_pkg::TBL_LO_BYTE];
      end else if (exec) begin
         mem_we = a_if.wr_mem; // see RULE3 see RULE6 see RULE8 see RULE12
      end else if (op_ready_o && load_we_i) begin
         mem_we = 1'b1;
         mem_waddr = load_addr_i;
         mem_wdata = load_data_i;
      end
   end

   xe_dmem #(
      .DEPTH(DEPTH),
      .AW(xe_pkg::DM_AW),
      .DW(xe_pkg::DATA_W)
   ) u_dmem (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(mem_wdata),
      .raddr_i(raddr),
      .rdata_o(rdata)
   );

   assign a_if.op = cur_op;
   assign a_if.acc = accum;
   assign a_if.mem = rdata;
   assign a_if.imm = cur_imm;
   assign a_if.bit_sel = cur_bit;
   assign a_if.cin = carry;

   xe_alu u_alu (
      .a_if(a_if)
   );

   // Program read issued on acceptance; data lands during execution
   always_comb begin
      if (op_i == xe_pkg::OP_TABLE_FETCH_LAST) begin
         next_prog_addr = {xe_pkg::LAST_PAGE, table_pointer_low_i}; // see RULE20
      end else begin
         next_prog_addr = {table_pointer_high_i, table_pointer_low_i};
      end
   end

   assign prog_rd_o = accept && table_op(op_i);
   assign prog_addr_o = prog_addr;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prog_addr <= '0;
      end else if (accept) begin
         prog_addr <= next_prog_addr;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (op_valid_i) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (a_if.skip) begin
               next_state = ST_DUMMY; // see RULE7
            end else begin
               next_state = ST_IDLE; // see RULE22
            end
         end
         ST_DUMMY: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cur_op <= xe_pkg::OP_SKIP_NIL;
         cur_addr <= '0;
         cur_bit <= '0;
         cur_imm <= '0;
      end else if (accept) begin
         cur_op <= op_i;
         cur_addr <= op_addr_i;
         cur_bit <= op_bit_i;
         cur_imm <= op_imm_i;
      end
   end

   // Accumulator only moves on forms that target it
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         accum <= xe_pkg::ACC_RST;
      end else if (exec && a_if.wr_acc) begin
         accum <= a_if.result; // see RULE1 see RULE2 see RULE5 see RULE9
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         carry <= xe_pkg::FLAG_RST;
      end else if (exec && (a_if.upd_arith || a_if.upd_c)) begin
         carry <= a_if.c_out; // see RULE4 see RULE1
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         zero <= xe_pkg::FLAG_RST;
      end else if (exec && (a_if.upd_arith || a_if.upd_z)) begin
         zero <= a_if.z_out; // see RULE22 see RULE21
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         half_carry_flag <= xe_pkg::FLAG_RST;
         signed_range_flag <= xe_pkg::FLAG_RST;
      end else if (exec && a_if.upd_arith) begin
         half_carry_flag <= a_if.ac_out; // see RULE2 see RULE3
         signed_range_flag <= a_if.ov_out;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         table_high_latch <= '0;
      end else if (exec && is_table) begin
         table_high_latch <= prog_data_i[xe_pkg::PROG_W-1:
                                         xe_pkg::TBL_HI_BYTE]; // see RULE19
      end
   end

   assign done_o = (exec && !a_if.skip) || (state == ST_DUMMY);
   assign skip_o = (state == ST_DUMMY);
   assign mem_data_o = rdata;
   assign accum_o = accum;
   assign carry_o = carry;
   assign zero_o = zero;
   assign half_carry_flag_o = half_carry_flag;
   assign signed_range_flag_o = signed_range_flag;
   assign table_high_latch_o = table_high_latch;

   rot_carry_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_ROT_RIGHT_FLAG_ACC && !mem_we |=>
      carry == $past(rdata[0]) &&
      accum == {$past(carry), $past(rdata[7:1])}) // see RULE1
      else $error("rotate right result or carry wrong");

   sub_borrow_acc_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_SUB_BORROW_ACC |=>
      accum == 8'($past(accum) - $past(rdata) -
                  {7'h00, ~$past(carry)})) // see RULE2
      else $error("borrow subtract result wrong");

   sub_mem_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && (cur_op == xe_pkg::OP_SUB_MEM ||
               cur_op == xe_pkg::OP_SUB_BORROW_MEM) |->
      mem_we && mem_waddr == cur_addr ##1 $stable(accum)) // see RULE6
      else $error("subtract to memory did not write memory only");

   sub_carry_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && (cur_op == xe_pkg::OP_SUB_ACC ||
               cur_op == xe_pkg::OP_SUB_MEM) |=>
      carry == ($past(accum) >= $past(rdata))) // see RULE4
      else $error("subtract carry polarity wrong");

   skip_two_cycle_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && a_if.skip |-> !done_o ##1 skip_o && done_o
      ##1 op_ready_o) // see RULE7
      else $error("skip did not take one dummy cycle");

   dec_skip_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_DEC_SKIP |->
      mem_we && mem_wdata == 8'(rdata - 8'h01) &&
      a_if.skip == (rdata == 8'h01) ##1
      $stable(carry) && $stable(zero)) // see RULE8
      else $error("decrement skip wrong");

   inc_acc_skip_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_INC_SKIP_ACC |->
      !mem_we && a_if.skip == (rdata == 8'hff) ##1
      accum == 8'($past(rdata) + 8'h01)) // see RULE13
      else $error("increment to accumulator skip wrong");

   set_byte_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_SET_BYTE |->
      mem_we && mem_wdata == 8'hff) // see RULE10
      else $error("set byte did not write all ones");

   bit_skip_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && (cur_op == xe_pkg::OP_SKIP_BIT_SET ||
               cur_op == xe_pkg::OP_SKIP_BIT_CLEAR) |->
      !mem_we && (a_if.skip == (rdata[cur_bit] ==
         (cur_op == xe_pkg::OP_SKIP_BIT_SET))) ##1
      $stable(accum) && $stable(carry)) // see RULE14 see RULE18
      else $error("bit test skip wrong");

   table_latch_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && is_table |=>
      table_high_latch == $past(prog_data_i[15:8])) // see RULE19
      else $error("table high byte not latched");

   last_page_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      prog_rd_o && op_i == xe_pkg::OP_TABLE_FETCH_LAST |=>
      prog_addr_o == {4'hf, $past(table_pointer_low_i)}) // see RULE20
      else $error("last page table address wrong");

   exor_zero_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      exec && cur_op == xe_pkg::OP_EXOR_ACC |=>
      zero == ($past(accum) == $past(rdata)) &&
      $stable(carry)) // see RULE21
      else $error("exclusive or zero flag wrong");
endmodule

// file: core/xe_pkg.sv
// Shared constants, opcodes and widths of the execute subset.
// Assumes an 8-bit data path and a 16-bit program word.
package xe_pkg;
   localparam int DATA_W = 8;
   localparam int PROG_W = 16;
   localparam int PADDR_W = 12;
   localparam int DM_DEPTH = 224;
   localparam int DM_AW = 8;
   localparam int BIT_W = 3;
   localparam int MSB = 7;
   localparam int NIB = 4;
   localparam int TBL_LO_BYTE = 0;
   localparam int TBL_HI_BYTE = 8;
   localparam logic [7:0] NIL = 8'h00;
   localparam logic [7:0] ONE = 8'h01;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [3:0] LAST_PAGE = 4'hf;

   typedef enum logic [4:0] {
      OP_ROT_RIGHT_FLAG_ACC,
      OP_SUB_BORROW_ACC,
      OP_SUB_BORROW_MEM,
      OP_SUB_ACC,
      OP_SUB_IMM,
      OP_SUB_MEM,
      OP_DEC_SKIP,
      OP_DEC_SKIP_ACC,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_INC_SKIP,
      OP_INC_SKIP_ACC,
      OP_SKIP_BIT_SET,
      OP_NIBBLE_MEM,
      OP_NIBBLE_ACC,
      OP_SKIP_NIL,
      OP_COPY_SKIP_NIL,
      OP_SKIP_BIT_CLEAR,
      OP_TABLE_FETCH,
      OP_TABLE_FETCH_LAST,
      OP_EXOR_ACC,
      OP_EXOR_IMM,
      OP_EXOR_MEM
   } xe_op_e;
endpackage

// file: tb/xe_testbench.sv
// Self-checking bench of the execute sequencer: corner and random ops.
// Assumes xe_exec timing as handed over; one clock, sync reset.
`timescale 1ns/100ps
module testbench;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic op_valid_i = 1'b0;
   xe_pkg::xe_op_e op_i = xe_pkg::OP_SET_BYTE;
   logic [7:0] op_addr_i = 8'h00;
   logic [2:0] op_bit_i = 3'h0;
   logic [7:0] op_imm_i = 8'h00;
   logic [3:0] tph = 4'h0;
   logic [7:0] tpl = 8'h00;
   logic [15:0] prog_data_i = 16'h0000;
   logic load_we_i = 1'b0;
   logic [7:0] load_addr_i = 8'h00;
   logic [7:0] load_data_i = 8'h00;
   logic op_ready_o, done_o, skip_o, prog_rd_o, carry_o, zero_o;
   logic half_carry_flag_o, signed_range_flag_o;
   logic [11:0] prog_addr_o;
   logic [7:0] mem_data_o, accum_o, table_high_latch_o;
   logic [7:0] mem [0:255];
   logic [7:0] e_acc, e_tl;
   logic e_c, e_z, e_ac, e_ov, e_skip;
   logic [31:0] rng = 32'h35dceaf9;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;

   xe_exec dut (.mclk_i(mclk_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
      .op_i(op_i), .op_addr_i(op_addr_i), .op_bit_i(op_bit_i),
      .op_imm_i(op_imm_i), .table_pointer_high_i(tph),
      .table_pointer_low_i(tpl), .prog_data_i(prog_data_i),
      .load_we_i(load_we_i), .load_addr_i(load_addr_i),
      .load_data_i(load_data_i), .op_ready_o(op_ready_o),
      .done_o(done_o), .skip_o(skip_o), .prog_rd_o(prog_rd_o),
      .prog_addr_o(prog_addr_o), .mem_data_o(mem_data_o),
      .accum_o(accum_o), .carry_o(carry_o), .zero_o(zero_o),
      .half_carry_flag_o(half_carry_flag_o),
      .signed_range_flag_o(signed_range_flag_o),
      .table_high_latch_o(table_high_latch_o));

   always #50 mclk_i = ~mclk_i;

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Cycle ceiling far above the at most about 1600 cycles the run needs
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 8000) begin
         bad_count++;
         end_sim;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
            seen, exp);
      end
   endtask

   function automatic void step();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
   endfunction

   // Returns overflow, half carry, carry, then the 8-bit difference
   function automatic logic [10:0] sub(input logic [7:0] a,
         input logic [7:0] b, input logic bw);
      logic [8:0] d;
      logic [4:0] h;
      d = {1'b0, a} - {1'b0, b} - {8'h00, bw};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
      // Overflow judged on the full difference, borrow included
      return {(a[7] != b[7]) && (d[7] != a[7]), ~h[4], ~d[8], d[7:0]};
   endfunction

   task automatic model(input xe_pkg::xe_op_e op, input logic [7:0] a,
         input logic [2:0] b, input logic [7:0] x, input logic [15:0] pw);
      logic [7:0] m, rs;
      logic [10:0] s;
      logic wa, wm, fs, fz;
      m = (a < 8'he0) ? mem[a] : 8'h00;
      {wa, wm, fs, fz, e_skip} = 5'b00000;
      rs = 8'h00;
      s = 11'h000;
      case (op)
         xe_pkg::OP_ROT_RIGHT_FLAG_ACC: begin
            rs = {e_c, m[7:1]};
            e_c = m[0];
            wa = 1'b1;
         end
         xe_pkg::OP_SUB_BORROW_ACC: {s, wa, fs} = {sub(e_acc, m, ~e_c), 2'b11};
         xe_pkg::OP_SUB_BORROW_MEM: {s, wm, fs} = {sub(e_acc, m, ~e_c), 2'b11};
         xe_pkg::OP_SUB_ACC: {s, wa, fs} = {sub(e_acc, m, 1'b0), 2'b11};
         xe_pkg::OP_SUB_IMM: {s, wa, fs} = {sub(e_acc, x, 1'b0), 2'b11};
         xe_pkg::OP_SUB_MEM: {s, wm, fs} = {sub(e_acc, m, 1'b0), 2'b11};
         xe_pkg::OP_DEC_SKIP: {rs, wm} = {m - 8'h01, 1'b1};
         xe_pkg::OP_DEC_SKIP_ACC: {rs, wa} = {m - 8'h01, 1'b1};
         xe_pkg::OP_SET_BYTE: {rs, wm} = {8'hff, 1'b1};
         xe_pkg::OP_SET_BIT: {rs, wm} = {m | (8'h01 << b), 1'b1};
         xe_pkg::OP_INC_SKIP: {rs, wm} = {m + 8'h01, 1'b1};
         xe_pkg::OP_INC_SKIP_ACC: {rs, wa} = {m + 8'h01, 1'b1};
         xe_pkg::OP_SKIP_BIT_SET: e_skip = m[b];
         xe_pkg::OP_NIBBLE_MEM: {rs, wm} = {m[3:0], m[7:4], 1'b1};
         xe_pkg::OP_NIBBLE_ACC: {rs, wa} = {m[3:0], m[7:4], 1'b1};
         xe_pkg::OP_SKIP_NIL: e_skip = (m == 8'h00);
         xe_pkg::OP_COPY_SKIP_NIL: {rs, wa, e_skip} = {m, 1'b1, m == 8'h00};
         xe_pkg::OP_SKIP_BIT_CLEAR: e_skip = ~m[b];
         xe_pkg::OP_EXOR_ACC: {rs, wa, fz} = {e_acc ^ m, 2'b11};
         xe_pkg::OP_EXOR_IMM: {rs, wa, fz} = {e_acc ^ x, 2'b11};
         xe_pkg::OP_EXOR_MEM: {rs, wm, fz} = {e_acc ^ m, 2'b11};
         default: {rs, wm, e_tl} = {pw[7:0], 1'b1, pw[15:8]};
      endcase
      if (fs)
         {e_ov, e_ac, e_c, rs} = s;
      if (fs || fz)
         e_z = (rs == 8'h00);
      if (op == xe_pkg::OP_DEC_SKIP || op == xe_pkg::OP_DEC_SKIP_ACC ||
            op == xe_pkg::OP_INC_SKIP || op == xe_pkg::OP_INC_SKIP_ACC)
         e_skip = (rs == 8'h00);
      if (wa)
         e_acc = rs;
      if (wm && a < 8'he0)
         mem[a] = rs;
   endtask

   task automatic load(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      load_we_i <= 1'b1;
      load_addr_i <= a;
      load_data_i <= d;
      @(posedge mclk_i);
      load_we_i <= 1'b0;
      mem[a] = d;
   endtask

   task automatic peek(input logic [7:0] a);
      logic [7:0] e;
      e = (a < 8'he0) ? mem[a] : 8'h00;
      @(posedge mclk_i);
      op_addr_i <= a;
      @(posedge mclk_i);
      #1;
      check(mem_data_o, e, "mem");
      // Memory contents also cover untouched-operand forms
   endtask

   task automatic run_op(input xe_pkg::xe_op_e op, input logic [7:0] a,
         input logic [2:0] b, input logic [7:0] x);
      logic tbl;
      logic [11:0] pa;
      logic [3:0] fl;
      step;
      tbl = (op == xe_pkg::OP_TABLE_FETCH);
      pa = {tbl ? rng[11:8] : 4'hf, rng[7:0]};
      tbl = tbl || (op == xe_pkg::OP_TABLE_FETCH_LAST);
      @(posedge mclk_i);
      op_valid_i <= 1'b1;
      op_i <= op;
      op_addr_i <= a;
      op_bit_i <= b;
      op_imm_i <= x;
      tph <= rng[11:8];
      tpl <= rng[7:0];
      prog_data_i <= rng[31:16];
      #1;
      check(prog_rd_o, tbl, "prog_rd");
      @(posedge mclk_i);
      op_valid_i <= 1'b0;
      #1;
      model(op, a, b, x, rng[31:16]);
      check(op_ready_o, 1'b0, "busy");
      check(done_o, !e_skip, "done");
      if (tbl)
         check(prog_addr_o, pa, "paddr");
      if (e_skip) begin
         @(posedge mclk_i);
         #1;
         check({skip_o, done_o, op_ready_o}, 3'b110, "skip");
      end else
         check(skip_o, 1'b0, "noskip");
      @(posedge mclk_i);
      #1;
      fl = {signed_range_flag_o, half_carry_flag_o, carry_o, zero_o};
      check(op_ready_o, 1'b1, "ready");
      check(accum_o, e_acc, "acc");
      check(fl, {e_ov, e_ac, e_c, e_z}, "flags");
      check(table_high_latch_o, e_tl, "latch");
      peek(a);
   endtask

   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'h00;
      {e_acc, e_tl, e_c, e_z, e_ac, e_ov} = 20'h00000;
      repeat (10) @(posedge mclk_i);
      srst_i <= 1'b0;
      #1;
      check(accum_o, 8'h00, "rst_acc");
      for (int i = 0; i < 17; i++) begin
         step;
         load((i == 16) ? 8'hdf : 8'(i), rng[7:0]);
      end
      // Boundary values that force skips and an unmapped write
      load(8'h01, 8'h01);
      load(8'h02, 8'hff);
      load(8'h03, 8'h00);
      run_op(xe_pkg::OP_DEC_SKIP, 8'h01, 3'h0, 8'h00);
      run_op(xe_pkg::OP_INC_SKIP_ACC, 8'h02, 3'h0, 8'h00);
      run_op(xe_pkg::OP_SKIP_BIT_SET, 8'h02, 3'h7, 8'h00);
      run_op(xe_pkg::OP_COPY_SKIP_NIL, 8'h03, 3'h0, 8'h00);
      run_op(xe_pkg::OP_SKIP_BIT_CLEAR, 8'h03, 3'h5, 8'h00);
      run_op(xe_pkg::OP_SUB_IMM, 8'h03, 3'h0, 8'h00);
      run_op(xe_pkg::OP_SET_BYTE, 8'hf0, 3'h0, 8'h00);
      for (int i = 0; i < 250; i++) begin
         step;
         run_op(xe_pkg::xe_op_e'(rng[4:0] % 5'd23),
            (rng[9:7] == 3'h0) ? 8'hdf : {4'h0, rng[13:10]},
            rng[16:14], rng[31:24]);
      end
      end_sim;
   end
endmodule
